// >>> core/aseq_step_config.sv
// Purpose: Step three and four configuration registers of the auxiliary converter sequencer.
// Assumes: APB slave, one clock; conversion engine pulses stepAdvance after each conversion.
// Notes: Read data is captured one cycle before the access completes.
`timescale 1ns/1ns
module aseq_step_config (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clkEn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [aseq_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic stepAdvance,
  output logic convActive,
  output logic [3:0] convStep,
  output aseq_pkg::aseq_gain_type convGain,
  output aseq_pkg::aseq_neg_type convNeg,
  output logic [3:0] convPos,
  output aseq_pkg::aseq_src_type convClass
);

  localparam int unsigned N = aseq_pkg::NUM_STEPS;
  localparam int unsigned IDXW = (N > 1) ? $clog2(N) : 1;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode
  function automatic logic addrHit(input logic [aseq_pkg::ADDR_W-1:0] a);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < int'(N); i++) begin
      if (a == aseq_pkg::STEP_ADDR[i]) begin
        hit = 1'b1;
      end
    end
    return hit;
  endfunction

  function automatic logic [IDXW-1:0] addrIndex(input logic [aseq_pkg::ADDR_W-1:0] a);
    logic [IDXW-1:0] idx;
    idx = '0;
    for (int i = 0; i < int'(N); i++) begin
      if (a == aseq_pkg::STEP_ADDR[i]) begin
        idx = IDXW'(i);
      end
    end
    return idx;
  endfunction

  logic [aseq_pkg::REG_W-1:0] cfg_q [N];
  logic [aseq_pkg::REG_W-1:0] cfg_d [N];
  logic [31:0] rdata_q, rdata_d;
  logic captured_q, captured_d;
  logic hit;
  logic [IDXW-1:0] hitIdx;
  logic doWrite;

  assign hit = addrHit(paddr);
  assign hitIdx = addrIndex(paddr);
  // Wait one state so read data can come from a flop
  assign pready = psel && penable && clkEn && captured_q;
  assign pslverr = pready && !hit;
  assign doWrite = pready && pwrite && hit;
  assign prdata = rdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // Register file
  always_comb begin
    for (int i = 0; i < int'(N); i++) begin
      cfg_d[i] = cfg_q[i];
    end
    // Reserved bits 12:5 stay zero
    if (doWrite) begin
      cfg_d[hitIdx] = pwdata[aseq_pkg::REG_W-1:0] & aseq_pkg::RW_MASK;
    end
    rdata_d = rdata_q;
    if (psel && !captured_q) begin
      rdata_d = hit ? {16'h0000, cfg_q[hitIdx]} : 32'h0000_0000;
    end
    captured_d = psel && !pready;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < int'(N); i++) begin
        cfg_q[i] <= aseq_pkg::STEP_RESET[i];
      end
      rdata_q <= 32'h0000_0000;
      captured_q <= 1'b0;
    end else if (clkEn) begin
      for (int i = 0; i < int'(N); i++) begin
        cfg_q[i] <= cfg_d[i];
      end
      rdata_q <= rdata_d;
      captured_q <= captured_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-step decode and sequencing
  logic [N-1:0] stepEnables;
  aseq_pkg::aseq_gain_type stepGain [N];
  aseq_pkg::aseq_neg_type stepNeg [N];
  logic [3:0] stepPos [N];
  aseq_pkg::aseq_src_type stepClass [N];

  genvar g;
  generate
    for (g = 0; g < int'(N); g++) begin : gStep
      assign stepEnables[g] = cfg_q[g][aseq_pkg::EN_BIT];
      aseq_step_decode uDecode (
        .cfg(cfg_q[g]),
        .gain(stepGain[g]),
        .negSrc(stepNeg[g]),
        .posCode(stepPos[g]),
        .posClass(stepClass[g])
      );
    end
  endgenerate

  logic [IDXW-1:0] seqIdx;
  logic seqActive;

  aseq_step_sequencer #(
    .NSTEPS(N),
    .IDXW(IDXW)
  ) uSeq (
    .clk(clk),
    .rst_n(rst_n),
    .clkEn(clkEn),
    .stepEnables(stepEnables),
    .stepAdvance(stepAdvance),
    .stepIdx(seqIdx),
    .seqActive(seqActive)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Registered converter settings for the current step
  logic active_q, active_d;
  logic [3:0] step_q, step_d;
  aseq_pkg::aseq_gain_type gain_q, gain_d;
  aseq_pkg::aseq_neg_type neg_q, neg_d;
  logic [3:0] pos_q, pos_d;
  aseq_pkg::aseq_src_type class_q, class_d;

  always_comb begin
    // A step cleared mid-run drops out at once rather than one conversion late
    active_d = seqActive && stepEnables[seqIdx];
    step_d = aseq_pkg::FIRST_STEP + 4'(seqIdx);
    gain_d = stepGain[seqIdx];
    neg_d = stepNeg[seqIdx];
    pos_d = stepPos[seqIdx];
    class_d = stepClass[seqIdx];
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      active_q <= 1'b0;
      step_q <= aseq_pkg::FIRST_STEP;
      gain_q <= aseq_pkg::ASEQ_GAIN_ONE;
      neg_q <= aseq_pkg::ASEQ_NEG_GROUND;
      pos_q <= aseq_pkg::STEP3_RESET[aseq_pkg::POS_HI:aseq_pkg::POS_LO];
      class_q <= aseq_pkg::ASEQ_SRC_EXTERNAL;
    end else if (clkEn) begin
      active_q <= active_d;
      step_q <= step_d;
      gain_q <= gain_d;
      neg_q <= neg_d;
      pos_q <= pos_d;
      class_q <= class_d;
    end
  end

  assign convActive = active_q;
  assign convStep = step_q;
  assign convGain = gain_q;
  assign convNeg = neg_q;
  assign convPos = pos_q;
  assign convClass = class_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  logic wrote_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wrote_q <= 1'b0;
    end else if (doWrite) begin
      wrote_q <= 1'b1;
    end
  end

  a_reset_values: assert property (@(posedge clk) disable iff (!rst_n)
    !wrote_q |-> (cfg_q[0] == aseq_pkg::STEP3_RESET && cfg_q[1] == aseq_pkg::STEP4_RESET))
    else $error("step register lost its reset value");

  a_step4_reset_pos: assert property (@(posedge clk) disable iff (!rst_n)
    !wrote_q |-> cfg_q[1][aseq_pkg::POS_HI:aseq_pkg::POS_LO] == 4'h4)
    else $error("step four positive field not at reset code");

  a_reserved_zero: assert property (@(posedge clk) disable iff (!rst_n)
    (pready && !pwrite) |-> (prdata[31:aseq_pkg::REG_W] == 16'h0000 &&
                             prdata[aseq_pkg::RSV_HI:aseq_pkg::RSV_LO] == 8'h00))
    else $error("reserved read data bits not zero");

  a_write_takes: assert property (@(posedge clk) disable iff (!rst_n)
    (doWrite && paddr == aseq_pkg::STEP4_ADDR) |=>
      cfg_q[1] == ($past(pwdata[aseq_pkg::REG_W-1:0]) & aseq_pkg::RW_MASK))
    else $error("write to step four not stored");

  a_one_wait: assert property (@(posedge clk) disable iff (!rst_n)
    (psel && !penable && clkEn ##1 psel && penable && clkEn) |-> pready)
    else $error("access phase not answered after one cycle");

  a_err_unmapped: assert property (@(posedge clk) disable iff (!rst_n)
    (pready && paddr != aseq_pkg::STEP3_ADDR && paddr != aseq_pkg::STEP4_ADDR) |-> pslverr)
    else $error("unmapped access not flagged");

  a_gain_four: assert property (@(posedge clk) disable iff (!rst_n)
    (clkEn && cfg_q[seqIdx][aseq_pkg::GAIN_HI]) |=> convGain == aseq_pkg::ASEQ_GAIN_FOUR)
    else $error("upper gain code not mapped to four");

  a_neg_auto: assert property (@(posedge clk) disable iff (!rst_n)
    (clkEn && aseq_pkg::autoNeg(cfg_q[seqIdx][aseq_pkg::POS_HI:aseq_pkg::POS_LO])) |=>
      convNeg == aseq_pkg::ASEQ_NEG_AUTO)
    else $error("negative select not overridden for internal source");

  a_neg_pin: assert property (@(posedge clk) disable iff (!rst_n)
    (clkEn && !aseq_pkg::autoNeg(cfg_q[seqIdx][aseq_pkg::POS_HI:aseq_pkg::POS_LO]) &&
     cfg_q[seqIdx][aseq_pkg::NEG_BIT]) |=> convNeg == aseq_pkg::ASEQ_NEG_EXT7)
    else $error("negative select one did not pick input seven");

  a_disabled_idle: assert property (@(posedge clk) disable iff (!rst_n)
    (clkEn && !cfg_q[seqIdx][aseq_pkg::EN_BIT]) |=> !convActive)
    else $error("disabled step reported active");

  a_active_enabled: assert property (@(posedge clk) disable iff (!rst_n)
    (clkEn && seqActive && cfg_q[seqIdx][aseq_pkg::EN_BIT]) |=> convActive)
    else $error("enabled step not reported active");

  a_read_step3: assert property (@(posedge clk) disable iff (!rst_n)
    (pready && !pwrite && paddr == aseq_pkg::STEP3_ADDR) |-> prdata == {16'h0000, cfg_q[0]})
    else $error("step three read data differs from register");

  a_read_step4: assert property (@(posedge clk) disable iff (!rst_n)
    (pready && !pwrite && paddr == aseq_pkg::STEP4_ADDR) |-> prdata == {16'h0000, cfg_q[1]})
    else $error("step four read data differs from register");

  a_freeze_state: assert property (@(posedge clk) disable iff (!rst_n)
    !clkEn |=> ($stable(cfg_q[0]) && $stable(cfg_q[1]) && $stable(seqIdx) && $stable(convStep) &&
                $stable(convActive)))
    else $error("state moved while clock enable low");

  a_step_number: assert property (@(posedge clk) disable iff (!rst_n)
    convActive |-> (convStep == aseq_pkg::FIRST_STEP || convStep == aseq_pkg::FIRST_STEP + 4'h1))
    else $error("active step number outside three and four");

  a_gain_one: assert property (@(posedge clk) disable iff (!rst_n)
    (clkEn && cfg_q[seqIdx][aseq_pkg::GAIN_HI:aseq_pkg::GAIN_LO] == aseq_pkg::GAIN_CODE_ONE) |=>
      convGain == aseq_pkg::ASEQ_GAIN_ONE)
    else $error("gain code zero not mapped to one");

  a_gain_two: assert property (@(posedge clk) disable iff (!rst_n)
    (clkEn && cfg_q[seqIdx][aseq_pkg::GAIN_HI:aseq_pkg::GAIN_LO] == aseq_pkg::GAIN_CODE_TWO) |=>
      convGain == aseq_pkg::ASEQ_GAIN_TWO)
    else $error("gain code one not mapped to two");

  a_neg_ground: assert property (@(posedge clk) disable iff (!rst_n)
    (clkEn && !aseq_pkg::autoNeg(cfg_q[seqIdx][aseq_pkg::POS_HI:aseq_pkg::POS_LO]) &&
     !cfg_q[seqIdx][aseq_pkg::NEG_BIT]) |=> convNeg == aseq_pkg::ASEQ_NEG_GROUND)
    else $error("negative select zero did not pick analog ground");

  a_class_external: assert property (@(posedge clk) disable iff (!rst_n)
    (clkEn && cfg_q[seqIdx][aseq_pkg::POS_HI:aseq_pkg::POS_LO] <= aseq_pkg::POS_EXT_LAST) |=>
      convClass == aseq_pkg::ASEQ_SRC_EXTERNAL)
    else $error("external code not classed as external input");

  a_class_temp: assert property (@(posedge clk) disable iff (!rst_n)
    (clkEn && cfg_q[seqIdx][aseq_pkg::POS_HI:aseq_pkg::POS_LO] == aseq_pkg::POS_TEMP) |=>
      convClass == aseq_pkg::ASEQ_SRC_TEMP)
    else $error("temperature code not classed as sensor");

  c_write_step3: cover property (@(posedge clk) disable iff (!rst_n)
    doWrite && paddr == aseq_pkg::STEP3_ADDR);

  c_both_steps: cover property (@(posedge clk) disable iff (!rst_n)
    convActive && convStep == 4'h3 ##[1:20] convActive && convStep == 4'h4);

  c_unmapped: cover property (@(posedge clk) disable iff (!rst_n)
    pslverr);

  c_internal: cover property (@(posedge clk) disable iff (!rst_n)
    convActive && convNeg == aseq_pkg::ASEQ_NEG_AUTO);

endmodule

// >>> core/aseq_pkg.sv
// Purpose: Shared constants and types for the auxiliary converter step configuration block.
// Assumes: 16-bit step registers on 32-bit APB words; register offsets are word indices.
// Notes: Byte address of a register is four times its index.
package aseq_pkg;

  localparam int unsigned REG_W = 16;
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned NUM_STEPS = 2;
  localparam logic [3:0] FIRST_STEP = 4'h3;

  ////////////////////////////////////////////////////////////////////////////
  // Register indices, byte addresses and reset values
  localparam logic [7:0] STEP3_IDX = 8'h93;
  localparam logic [7:0] STEP4_IDX = 8'h94;
  localparam logic [ADDR_W-1:0] STEP3_ADDR = {2'h0, STEP3_IDX, 2'h0};
  localparam logic [ADDR_W-1:0] STEP4_ADDR = {2'h0, STEP4_IDX, 2'h0};
  localparam logic [REG_W-1:0] STEP3_RESET = 16'h0003;
  localparam logic [REG_W-1:0] STEP4_RESET = 16'h0004;
  localparam logic [ADDR_W-1:0] STEP_ADDR [NUM_STEPS] = '{STEP3_ADDR, STEP4_ADDR};
  localparam logic [REG_W-1:0] STEP_RESET [NUM_STEPS] = '{STEP3_RESET, STEP4_RESET};

  ////////////////////////////////////////////////////////////////////////////
  // Field layout
  localparam int unsigned EN_BIT = 15;
  localparam int unsigned GAIN_HI = 14;
  localparam int unsigned GAIN_LO = 13;
  localparam int unsigned RSV_HI = 12;
  localparam int unsigned RSV_LO = 5;
  localparam int unsigned NEG_BIT = 4;
  localparam int unsigned POS_HI = 3;
  localparam int unsigned POS_LO = 0;
  localparam logic [REG_W-1:0] RW_MASK = 16'hE01F;

  ////////////////////////////////////////////////////////////////////////////
  // Encodings
  localparam logic [1:0] GAIN_CODE_ONE = 2'h0;
  localparam logic [1:0] GAIN_CODE_TWO = 2'h1;
  localparam logic [3:0] POS_EXT_LAST = 4'h7;
  localparam logic [3:0] POS_TEMP = 4'h8;
  localparam logic [3:0] POS_SHORT = 4'h9;
  localparam logic [3:0] POS_DAC = 4'hA;

  typedef enum logic [1:0] {
    ASEQ_GAIN_ONE = 2'b00,
    ASEQ_GAIN_TWO = 2'b01,
    ASEQ_GAIN_FOUR = 2'b10
  } aseq_gain_type;

  typedef enum logic [1:0] {
    ASEQ_NEG_GROUND = 2'b00,
    ASEQ_NEG_EXT7 = 2'b01,
    ASEQ_NEG_AUTO = 2'b10
  } aseq_neg_type;

  typedef enum logic [2:0] {
    ASEQ_SRC_EXTERNAL = 3'b000,
    ASEQ_SRC_TEMP = 3'b001,
    ASEQ_SRC_SHORT = 3'b010,
    ASEQ_SRC_DAC = 3'b011,
    ASEQ_SRC_SUPPLY = 3'b100
  } aseq_src_type;

  typedef enum logic [0:0] {
    ASEQ_IDLE = 1'b0,
    ASEQ_RUN = 1'b1
  } aseq_state_type;

  // Internal sources pick their own negative input
  function automatic logic autoNeg(input logic [3:0] pos);
    return pos > POS_EXT_LAST;
  endfunction

endpackage

// >>> core/aseq_step_decode.sv
// Purpose: Decodes one step configuration word into converter settings.
// Assumes: Purely combinational; caller registers the results.
// Notes: Supply monitor codes are passed through as raw positive code.
`timescale 1ns/1ns
module aseq_step_decode (
  input wire logic [aseq_pkg::REG_W-1:0] cfg,
  output aseq_pkg::aseq_gain_type gain,
  output aseq_pkg::aseq_neg_type negSrc,
  output logic [3:0] posCode,
  output aseq_pkg::aseq_src_type posClass
);

  logic [3:0] pos;

  always_comb begin
    pos = cfg[aseq_pkg::POS_HI:aseq_pkg::POS_LO];
    posCode = pos;
    // Both upper codes mean four
    case (cfg[aseq_pkg::GAIN_HI:aseq_pkg::GAIN_LO])
      aseq_pkg::GAIN_CODE_ONE: gain = aseq_pkg::ASEQ_GAIN_ONE;
      aseq_pkg::GAIN_CODE_TWO: gain = aseq_pkg::ASEQ_GAIN_TWO;
      default: gain = aseq_pkg::ASEQ_GAIN_FOUR;
    endcase
    if (aseq_pkg::autoNeg(pos)) begin
      negSrc = aseq_pkg::ASEQ_NEG_AUTO;
    end else if (cfg[aseq_pkg::NEG_BIT]) begin
      negSrc = aseq_pkg::ASEQ_NEG_EXT7;
    end else begin
      negSrc = aseq_pkg::ASEQ_NEG_GROUND;
    end
    case (pos)
      aseq_pkg::POS_TEMP: posClass = aseq_pkg::ASEQ_SRC_TEMP;
      aseq_pkg::POS_SHORT: posClass = aseq_pkg::ASEQ_SRC_SHORT;
      aseq_pkg::POS_DAC: posClass = aseq_pkg::ASEQ_SRC_DAC;
      default: posClass = (pos > aseq_pkg::POS_EXT_LAST) ? aseq_pkg::ASEQ_SRC_SUPPLY
                                                         : aseq_pkg::ASEQ_SRC_EXTERNAL;
    endcase
  end

endmodule

// >>> core/aseq_step_sequencer.sv
// Purpose: Walks the enabled steps in ascending order, skipping disabled ones.
// Assumes: stepAdvance is a one-cycle pulse on the same clock.
// Notes: Wraps to the lowest enabled step after the highest.
`timescale 1ns/1ns
module aseq_step_sequencer #(
  parameter int unsigned NSTEPS = 2,
  parameter int unsigned IDXW = (NSTEPS > 1) ? $clog2(NSTEPS) : 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clkEn,
  input wire logic [NSTEPS-1:0] stepEnables,
  input wire logic stepAdvance,
  output logic [IDXW-1:0] stepIdx,
  output logic seqActive
);

  aseq_pkg::aseq_state_type state_q, state_d;
  logic [IDXW-1:0] idx_q, idx_d;

  function automatic logic [IDXW-1:0] nextEnabled(input logic [NSTEPS-1:0] en, input logic [IDXW-1:0] cur);
    logic [IDXW-1:0] res;
    logic found;
    int k;
    res = cur;
    found = 1'b0;
    k = 0;
    for (int i = 1; i <= int'(NSTEPS); i++) begin
      k = (int'(cur) + i) % int'(NSTEPS);
      if (!found && en[k]) begin
        res = IDXW'(k);
        found = 1'b1;
      end
    end
    return res;
  endfunction

  always_comb begin
    state_d = state_q;
    idx_d = idx_q;
    case (state_q)
      aseq_pkg::ASEQ_IDLE: begin
        if (|stepEnables) begin
          state_d = aseq_pkg::ASEQ_RUN;
          idx_d = nextEnabled(stepEnables, IDXW'(NSTEPS - 1));
        end
      end
      aseq_pkg::ASEQ_RUN: begin
        if (!(|stepEnables)) begin
          state_d = aseq_pkg::ASEQ_IDLE;
        end else if (stepAdvance || !stepEnables[idx_q]) begin
          idx_d = nextEnabled(stepEnables, idx_q);
        end
      end
      default: state_d = aseq_pkg::ASEQ_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= aseq_pkg::ASEQ_IDLE;
      idx_q <= '0;
    end else if (clkEn) begin
      state_q <= state_d;
      idx_q <= idx_d;
    end
  end

  assign stepIdx = idx_q;
  assign seqActive = (state_q == aseq_pkg::ASEQ_RUN);

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  a_run_needs_enable: assert property (@(posedge clk) disable iff (!rst_n)
    (clkEn && !(|stepEnables)) |=> !seqActive)
    else $error("sequencer running with no step enabled");

  a_advance_ascending: assert property (@(posedge clk) disable iff (!rst_n)
    (clkEn && seqActive && stepAdvance && (&stepEnables) && stepIdx == '0) |=> stepIdx == IDXW'(1))
    else $error("sequencer did not advance to next step");

endmodule

// >>> dv/tb_top.sv
// Purpose: Self-checking bench for the step three and four configuration registers.
// Assumes: APB answers after one access cycle; conv outputs settle within three edges of a cause.
// Notes: Reference model keeps both registers and the decode as plain values.
`timescale 1ns/1ns
`define CHK(nm, e, a) begin numChecks++; if ((a) !== (e)) begin mismatches++; \
  $display("wrong value %s expected %0h seen %0h", nm, e, a); end end
module tb_top;
  logic clk;
  logic rst_n;
  logic clkEn;
  logic psel;
  logic penable;
  logic pwrite;
  logic stepAdvance;
  logic [aseq_pkg::ADDR_W-1:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic [31:0] rdata;
  logic pready;
  logic pslverr;
  logic err;
  logic convActive;
  logic [3:0] convStep;
  logic [3:0] convPos;
  aseq_pkg::aseq_gain_type convGain;
  aseq_pkg::aseq_neg_type convNeg;
  aseq_pkg::aseq_src_type convClass;
  logic [15:0] model [2];
  logic [15:0] v;
  int mismatches = 0;
  int numChecks = 0;
  int cycles = 0;
  localparam int LIMIT = 20000;

  aseq_step_config i_dut (.clk(clk), .rst_n(rst_n), .clkEn(clkEn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .stepAdvance(stepAdvance), .convActive(convActive), .convStep(convStep), .convGain(convGain),
    .convNeg(convNeg), .convPos(convPos), .convClass(convClass));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task complete_run;
    $display("checks %0d mismatches %0d", numChecks, mismatches);
    if (mismatches == 0 && numChecks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Hang guard; the full run needs well under a thousand cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      mismatches++;
      complete_run();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Expected decode
  function automatic logic [1:0] expGain(input logic [1:0] g);
    return (g == 2'h0) ? 2'h0 : (g == 2'h1) ? 2'h1 : 2'h2;
  endfunction

  function automatic logic [1:0] expNeg(input logic [15:0] c);
    return (c[3:0] > 4'h7) ? 2'h2 : {1'b0, c[4]};
  endfunction

  function automatic logic [2:0] expClass(input logic [3:0] p);
    if (p < 4'h8) return 3'h0;
    if (p == 4'h8) return 3'h1;
    if (p == 4'h9) return 3'h2;
    if (p == 4'hA) return 3'h3;
    return 3'h4;
  endfunction

  function automatic logic [11:0] addrOf(input int i);
    return (i == 0) ? aseq_pkg::STEP3_ADDR : aseq_pkg::STEP4_ADDR;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // APB master; an idle cycle precedes each transfer so no signal is driven twice in one step
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input int stall);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    penable <= 1'b0;
    @(posedge clk);
    penable <= 1'b1;
    if (stall > 0) begin
      clkEn <= 1'b0;
      repeat (stall) begin
        @(posedge clk);
        `CHK("stalled ready", 1'b0, pready)
      end
      clkEn <= 1'b1;
    end
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1);
    `CHK("ready", 1'b1, pready)
    `CHK("wait cycles", 1, n)
    rdata = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic regWrite(input int i, input logic [15:0] d);
    apb(1'b1, addrOf(i), {16'($urandom), d}, 0);
    model[i] = d & 16'hE01F;
    `CHK("write err", 1'b0, err)
  endtask

  task automatic chkRead(input int i, input int stall);
    apb(1'b0, addrOf(i), $urandom, stall);
    `CHK("read data", {16'h0000, model[i]}, rdata)
    `CHK("read err", 1'b0, err)
  endtask

  task automatic chkConv(input logic [3:0] st, input logic [15:0] c);
    repeat (3) @(posedge clk);
    #1;
    `CHK("active", 1'b1, convActive)
    `CHK("step", st, convStep)
    `CHK("gain", expGain(c[14:13]), convGain)
    `CHK("neg", expNeg(c), convNeg)
    `CHK("pos", c[3:0], convPos)
    `CHK("class", expClass(c[3:0]), convClass)
  endtask

  task automatic pulse;
    @(posedge clk);
    stepAdvance <= 1'b1;
    @(posedge clk);
    stepAdvance <= 1'b0;
  endtask

  task automatic doReset;
    rst_n <= 1'b0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    model[0] = 16'h0003;
    model[1] = 16'h0004;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clkEn = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    stepAdvance = 1'b0;
    rst_n = 1'b0;
    v = '0;
    void'($urandom(32'hb616));
    doReset();
    chkRead(0, 0);
    chkRead(1, 3);
    `CHK("idle active", 1'b0, convActive)
    // Random words; reserved bits must read back as zero
    for (int k = 0; k < 8; k++) begin
      regWrite(k % 2, 16'($urandom));
      chkRead(k % 2, 0);
    end
    // Unmapped word next to the block: refused, no side effect
    apb(1'b1, 12'h248, 32'h0000FFFF, 0);
    `CHK("unmapped write err", 1'b1, err)
    apb(1'b0, 12'h248, 32'h0, 0);
    `CHK("unmapped err", 1'b1, err)
    `CHK("unmapped data", 32'h0, rdata)
    chkRead(0, 0);
    chkRead(1, 0);
    // Every positive code with both negative selects; all gain codes across the loop, two per positive code
    regWrite(1, 16'h0004);
    for (int c = 0; c < 32; c++) begin
      v = {1'b1, 2'(c >> 3), 8'($urandom), 1'(c >> 4), 4'(c)};
      regWrite(0, v);
      chkConv(4'h3, model[0]);
    end
    // Ascending order, wrap, and skipping of disabled steps
    regWrite(0, 16'h8005);
    regWrite(1, 16'hA018);
    chkConv(4'h3, model[0]);
    pulse();
    chkConv(4'h4, model[1]);
    pulse();
    chkConv(4'h3, model[0]);
    regWrite(0, 16'h0005);
    chkConv(4'h4, model[1]);
    regWrite(1, 16'h2018);
    pulse();
    repeat (3) @(posedge clk);
    #1;
    `CHK("none active", 1'b0, convActive)
    // Reset in mid-run restores both registers
    regWrite(0, 16'hFFFF);
    regWrite(1, 16'hFFFF);
    doReset();
    chkRead(0, 0);
    chkRead(1, 0);
    `CHK("reset active", 1'b0, convActive)
    `CHK("reset step", 4'h3, convStep)
    `CHK("reset pos", 4'h3, convPos)
    complete_run();
  end
endmodule
